// >>> rtl/tw_pkg.sv
package tw_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int SCL_MAX_HZ = 100_000;
  // quarter of the period of the fastest legal serial clock, rounded up
  localparam int QTR_CYCLES = (CLK_HZ + 4 * SCL_MAX_HZ - 1) / (4 * SCL_MAX_HZ);
  localparam int PROG_TIME_MS = 10;
  localparam int PROG_CYCLES = PROG_TIME_MS * (CLK_HZ / 1000);
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int ROW_LSB = 2;
  localparam int PAGE_BYTES = 4;
  localparam int MEM_BYTES = 128;
  localparam int FIFO_DEPTH = 32;
  localparam int LEN_W = 3;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] DONE_SLOT = 4'h9;
  localparam logic [7:0] MEM_RESET = 8'hff;
  localparam logic DIR_READ = 1'b1;
endpackage

// >>> rtl/tw_link_if.sv
`timescale 1ns/100ps
interface tw_link_if;
  logic scl;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic sda;
  // open-drain wire with pull-up: low when any enabled driver drives low
  assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
  modport master (output scl, output sda_m_o, output sda_m_oe, input sda);
  modport device (input scl, input sda, output sda_s_o, output sda_s_oe);
endinterface // tw_link_if

// >>> rtl/tw_fifo.sv
`timescale 1ns/100ps
module tw_fifo #(
  parameter int WIDTH = tw_pkg::DATA_W,
  parameter int DEPTH = tw_pkg::FIFO_DEPTH
) (
  input logic clock,
  input logic nrst,
  input logic in_valid,
  output logic in_ready,
  input logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic in_ready_q, out_valid_q;
  logic push, pop;

  assign push = in_valid && in_ready_q;
  assign pop = out_valid_q && out_ready;
  assign in_ready = in_ready_q;
  assign out_valid = out_valid_q;
  assign out_data = mem_q[rp_q];

  always_comb begin
    mem_d = mem_q;
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wp_q] = in_data;
      wp_d = (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
    end
    if (pop) begin
      rp_d = (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      in_ready_q <= 1'b1;
      out_valid_q <= 1'b0;
    end else begin
      mem_q <= mem_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      in_ready_q <= (cnt_d != (AW + 1)'(DEPTH));
      out_valid_q <= (cnt_d != '0);
    end
  end
endmodule // tw_fifo

// >>> rtl/tw_eeprom.sv
`timescale 1ns/100ps
// Summary of operation
// RULE1 - master starts, sends seven address bits, direction
// RULE2 - eighth bit one reads, zero writes
// RULE3 - device pulls data low in ninth clock
// RULE4 - write address acknowledged, then data bytes awaited
// RULE5 - lock high through address: no write, no ack
// RULE6 - byte write: one byte, ack, then stop
// RULE7 - page write: up to four bytes, one row
// RULE8 - only two low counter bits increment
// RULE9 - master avoids overrunning the row; tw_master does not check the length, so extra bytes wrap within the row
// RULE10 - stop after write launches program cycle
// RULE11 - busy: inputs ignored, bus released, no answer
// RULE12 - program cycle lasts at most ten milliseconds
// RULE13 - serial clock no faster than 100 kHz
// RULE14 - polling: no ack while busy, ack when ready
// RULE15 - read: no master ack ends transfer
// RULE16 - start/stop are data edges while clock high
// RULE17 - 128 bytes; address latched after opening byte
module tw_eeprom #(
  parameter int PROG_CYCLES = tw_pkg::PROG_CYCLES
) (
  input logic clock,
  input logic nrst,
  tw_link_if.device link,
  input logic write_lock_input,
  output logic busy
);
  localparam int TW = $clog2(PROG_CYCLES + 1);
  localparam int AW = tw_pkg::ADDR_W;
  localparam int RL = tw_pkg::ROW_LSB;
  localparam int PAGE = tw_pkg::PAGE_BYTES;
  localparam int MB = tw_pkg::MEM_BYTES;

  typedef logic [tw_pkg::DATA_W-1:0] tw_byte_t;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_WDATA,
    ST_RDATA,
    ST_PROG
  } tw_dev_state_e;

  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q;
  logic wc_s1_q, wc_s2_q;
  tw_dev_state_e state_q, state_d;
  logic [3:0] bcnt_q, bcnt_d;
  tw_byte_t shift_q, shift_d;
  logic [AW-1:0] addr_q, addr_d;
  logic lock_q, lock_d;
  logic oe_q, oe_d;
  logic busy_q, busy_d;
  tw_byte_t pbuf_q [PAGE];
  tw_byte_t pbuf_d [PAGE];
  logic [PAGE-1:0] pmask_q, pmask_d;
  logic [TW-1:0] timer_q, timer_d;
  tw_byte_t mem_q [MB];
  tw_byte_t mem_d [MB];
  logic commit;
  logic scl_rise, scl_fall, start_det, stop_det;

  assign link.sda_s_o = 1'b0;
  assign link.sda_s_oe = oe_q;
  assign busy = busy_q;

  // pins idle high, so the clock and data synchronisers reset high to avoid a false start
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
      wc_s1_q <= 1'b0;
      wc_s2_q <= 1'b0;
    end else begin
      scl_s1_q <= link.scl;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= link.sda;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
      wc_s1_q <= write_lock_input;
      wc_s2_q <= wc_s1_q;
    end
  end

  assign scl_rise = scl_s2_q && !scl_s3_q;
  assign scl_fall = !scl_s2_q && scl_s3_q;
  assign start_det = scl_s2_q && scl_s3_q && !sda_s2_q && sda_s3_q; // RULE16
  assign stop_det = scl_s2_q && scl_s3_q && sda_s2_q && !sda_s3_q; // RULE16

  always_comb begin
    state_d = state_q;
    bcnt_d = bcnt_q;
    shift_d = shift_q;
    addr_d = addr_q;
    lock_d = lock_q;
    oe_d = oe_q;
    pbuf_d = pbuf_q;
    pmask_d = pmask_q;
    timer_d = timer_q;
    commit = 1'b0;
    if (state_q == ST_PROG) begin
      // deaf and released until the cycle ends
      oe_d = 1'b0; // RULE11
      if (timer_q == TW'(PROG_CYCLES - 1)) begin // RULE12
        commit = 1'b1;
        pmask_d = '0;
        state_d = ST_IDLE; // RULE14
      end else begin
        timer_d = timer_q + 1'b1;
      end
    end else if (start_det) begin
      state_d = ST_ADDR; // RULE1
      bcnt_d = '0;
      oe_d = 1'b0;
      pmask_d = '0;
      lock_d = wc_s2_q; // RULE5
    end else if (stop_det) begin
      oe_d = 1'b0;
      state_d = ST_IDLE;
      if (state_q == ST_WDATA && |pmask_q && !lock_q) begin
        state_d = ST_PROG; // RULE10
        timer_d = '0;
      end
    end else begin
      if (state_q == ST_ADDR) begin
        lock_d = lock_q | wc_s2_q; // RULE5
      end
      if (state_q != ST_IDLE && scl_rise) begin
        if (bcnt_q < tw_pkg::ACK_SLOT) begin
          // msb first; in reads this also advances the outgoing bit
          shift_d = {shift_q[tw_pkg::DATA_W-2:0], sda_s2_q}; // RULE1
          bcnt_d = bcnt_q + 4'h1;
        end else if (state_q == ST_RDATA && sda_s2_q) begin
          state_d = ST_IDLE; // RULE15
        end else begin
          bcnt_d = tw_pkg::DONE_SLOT;
        end
      end
      if (state_q != ST_IDLE && scl_fall) begin
        if (bcnt_q == tw_pkg::ACK_SLOT) begin
          if (state_q == ST_ADDR) begin
            addr_d = shift_q[tw_pkg::DATA_W-1:1]; // RULE17
            oe_d = 1'b1; // RULE3 RULE4
          end else if (state_q == ST_WDATA) begin
            oe_d = !lock_q; // RULE5 RULE6 RULE7
            if (!lock_q) begin
              pbuf_d[addr_q[RL-1:0]] = shift_q; // RULE7
              pmask_d[addr_q[RL-1:0]] = 1'b1;
              // row bits stay, the byte counter wraps in the row
              addr_d = {addr_q[AW-1:RL], addr_q[RL-1:0] + 2'h1}; // RULE8
            end
          end else begin
            // release so the master can acknowledge
            oe_d = 1'b0; // RULE15
            addr_d = addr_q + 7'h01;
          end
        end else if (bcnt_q == tw_pkg::DONE_SLOT) begin
          bcnt_d = '0;
          oe_d = 1'b0;
          if (state_q == ST_WDATA ||
              (state_q == ST_ADDR && shift_q[0] != tw_pkg::DIR_READ)) begin
            state_d = ST_WDATA; // RULE2 RULE4
          end else begin
            state_d = ST_RDATA; // RULE2
            shift_d = mem_q[addr_q];
            oe_d = !mem_q[addr_q][tw_pkg::DATA_W-1];
          end
        end else if (state_q == ST_RDATA) begin
          oe_d = !shift_q[tw_pkg::DATA_W-1];
        end
      end
    end
    busy_d = (state_d == ST_PROG);
  end

  // the page latch reaches the array only when the program cycle ends
  always_comb begin
    mem_d = mem_q;
    for (int i = 0; i < PAGE; i++) begin
      if (commit && pmask_q[i]) begin
        mem_d[{addr_q[AW-1:RL], RL'(i)}] = pbuf_q[i]; // RULE7 RULE10
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      bcnt_q <= '0;
      shift_q <= '0;
      addr_q <= '0;
      lock_q <= 1'b0;
      oe_q <= 1'b0;
      busy_q <= 1'b0;
      pmask_q <= '0;
      timer_q <= '0;
      for (int i = 0; i < PAGE; i++) begin
        pbuf_q[i] <= '0;
      end
      for (int i = 0; i < MB; i++) begin
        mem_q[i] <= tw_pkg::MEM_RESET;
      end
    end else begin
      state_q <= state_d;
      bcnt_q <= bcnt_d;
      shift_q <= shift_d;
      addr_q <= addr_d;
      lock_q <= lock_d;
      oe_q <= oe_d;
      busy_q <= busy_d;
      pmask_q <= pmask_d;
      timer_q <= timer_d;
      pbuf_q <= pbuf_d;
      mem_q <= mem_d;
    end
  end
endmodule // tw_eeprom

// >>> rtl/tw_master.sv
`timescale 1ns/100ps
module tw_master #(
  parameter int QTR_CYCLES = tw_pkg::QTR_CYCLES,
  parameter int FIFO_DEPTH = tw_pkg::FIFO_DEPTH
) (
  input logic clock,
  input logic nrst,
  tw_link_if.master link,
  input logic cmd_valid,
  output logic cmd_ready,
  input logic cmd_read,
  input logic cmd_poll,
  input logic [tw_pkg::ADDR_W-1:0] cmd_addr,
  input logic [tw_pkg::LEN_W-1:0] cmd_len,
  input logic wr_valid,
  output logic wr_ready,
  input logic [tw_pkg::DATA_W-1:0] wr_data,
  output logic rd_valid,
  output logic [tw_pkg::DATA_W-1:0] rd_data,
  output logic done,
  output logic nack
);
  localparam int DW = $clog2(QTR_CYCLES + 1);
  localparam int LW = tw_pkg::LEN_W;
  typedef logic [tw_pkg::DATA_W-1:0] tw_byte_t;
  typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} tw_mst_state_e;

  tw_mst_state_e state_q, state_d;
  logic [DW-1:0] div_q, div_d;
  logic [1:0] phase_q, phase_d;
  logic [3:0] bit_q, bit_d;
  tw_byte_t tx_q, tx_d, rx_q, rx_d, hdr_q, hdr_d, rd_data_q, rd_data_d;
  logic [LW-1:0] left_q, left_d, len_q, len_d;
  logic read_q, read_d, poll_q, poll_d, reading_q, reading_d;
  logic is_addr_q, is_addr_d, restart_q, restart_d;
  logic scl_q, scl_d, oe_q, oe_d;
  logic cmd_ready_q, cmd_ready_d, rd_valid_q, rd_valid_d;
  logic done_q, done_d, nack_q, nack_d;
  logic sda_s1_q, sda_s2_q;
  logic tick, ack_ok, last, end_byte, next_write, advance, f_pop, f_valid;
  tw_byte_t f_data;

  tw_fifo #(.WIDTH(tw_pkg::DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .nrst(nrst),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_data),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  assign link.scl = scl_q;
  assign link.sda_m_o = 1'b0;
  assign link.sda_m_oe = oe_q;
  assign cmd_ready = cmd_ready_q;
  assign rd_valid = rd_valid_q;
  assign rd_data = rd_data_q;
  assign done = done_q;
  assign nack = nack_q;

  assign tick = (div_q == DW'(QTR_CYCLES - 1)); // RULE13
  assign ack_ok = !sda_s2_q;
  assign last = (left_q == LW'(1));
  assign end_byte = state_q == M_BIT && phase_q == 2'h3 &&
                    bit_q == tw_pkg::ACK_SLOT;
  assign next_write = !read_q && ack_ok && (is_addr_q || !last);
  // an empty fifo holds the clock high before the next data byte
  assign advance = tick && !(end_byte && next_write && !f_valid);

  always_comb begin
    state_d = state_q;
    div_d = tick ? '0 : div_q + 1'b1;
    phase_d = phase_q;
    bit_d = bit_q;
    tx_d = tx_q;
    rx_d = rx_q;
    hdr_d = hdr_q;
    left_d = left_q;
    len_d = len_q;
    read_d = read_q;
    poll_d = poll_q;
    reading_d = reading_q;
    is_addr_d = is_addr_q;
    restart_d = restart_q;
    cmd_ready_d = cmd_ready_q;
    rd_valid_d = 1'b0;
    rd_data_d = rd_data_q;
    done_d = 1'b0;
    nack_d = nack_q;
    f_pop = 1'b0;
    unique case (state_q)
      M_IDLE: begin
        if (cmd_valid) begin
          state_d = M_START;
          div_d = '0;
          phase_d = '0;
          cmd_ready_d = 1'b0;
          nack_d = 1'b0;
          read_d = cmd_read;
          poll_d = cmd_poll;
          len_d = cmd_len;
          hdr_d = {cmd_addr, cmd_read}; // RULE1 RULE2
        end
      end
      M_START: begin
        if (advance) begin
          phase_d = phase_q + 2'h1;
          if (phase_q == 2'h3) begin
            state_d = M_BIT;
            bit_d = '0;
            is_addr_d = 1'b1;
            reading_d = 1'b0;
            tx_d = hdr_q;
            left_d = len_q;
          end
        end
      end
      M_BIT: begin
        if (advance) begin
          phase_d = phase_q + 2'h1;
          if (phase_q == 2'h3 && bit_q != tw_pkg::ACK_SLOT) begin
            bit_d = bit_q + 4'h1;
            tx_d = {tx_q[tw_pkg::DATA_W-2:0], 1'b0}; // RULE1
            rx_d = {rx_q[tw_pkg::DATA_W-2:0], sda_s2_q};
          end else if (phase_q == 2'h3) begin
            bit_d = '0;
            is_addr_d = 1'b0;
            if (reading_q) begin
              rd_valid_d = 1'b1;
              rd_data_d = rx_q;
            end
            if (!is_addr_q) begin
              left_d = left_q - LW'(1);
            end
            if (is_addr_q && !ack_ok && poll_q) begin
              state_d = M_STOP; // RULE14
              restart_d = 1'b1;
            end else if (!reading_q && !ack_ok) begin
              state_d = M_STOP;
              nack_d = 1'b1;
            end else if (!is_addr_q && last) begin
              state_d = M_STOP; // RULE6 RULE7
            end else begin
              reading_d = read_q;
              if (next_write) begin
                tx_d = f_data;
                f_pop = 1'b1;
              end
            end
          end
        end
      end
      M_STOP: begin
        if (advance) begin
          phase_d = phase_q + 2'h1;
          if (phase_q == 2'h3) begin
            restart_d = 1'b0;
            if (restart_q) begin
              state_d = M_START;
            end else begin
              state_d = M_IDLE;
              done_d = 1'b1;
              cmd_ready_d = 1'b1;
            end
          end
        end
      end
    endcase
    // quarters 2 and 3 of every bit hold the clock high
    scl_d = (state_d == M_IDLE) || (state_d == M_START) || phase_d[1];
    // in data bits, data moves only in quarter 1, after the clock is already low
    unique case (state_d)
      M_IDLE: oe_d = 1'b0;
      M_START: oe_d = phase_d[1]; // RULE16
      M_BIT: begin
        if (phase_d == 2'h0) begin
          oe_d = oe_q;
        end else if (bit_d != tw_pkg::ACK_SLOT) begin
          oe_d = !reading_d && !tx_d[tw_pkg::DATA_W-1];
        end else begin
          oe_d = reading_d && !last; // RULE15
        end
      end
      M_STOP: oe_d = (phase_d == 2'h0) ? oe_q : (phase_d != 2'h3); // RULE16
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= M_IDLE;
      div_q <= '0;
      phase_q <= '0;
      bit_q <= '0;
      tx_q <= '0;
      rx_q <= '0;
      hdr_q <= '0;
      left_q <= '0;
      len_q <= '0;
      read_q <= 1'b0;
      poll_q <= 1'b0;
      reading_q <= 1'b0;
      is_addr_q <= 1'b0;
      restart_q <= 1'b0;
      scl_q <= 1'b1;
      oe_q <= 1'b0;
      cmd_ready_q <= 1'b1;
      rd_valid_q <= 1'b0;
      rd_data_q <= '0;
      done_q <= 1'b0;
      nack_q <= 1'b0;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
    end else begin
      state_q <= state_d;
      div_q <= div_d;
      phase_q <= phase_d;
      bit_q <= bit_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      hdr_q <= hdr_d;
      left_q <= left_d;
      len_q <= len_d;
      read_q <= read_d;
      poll_q <= poll_d;
      reading_q <= reading_d;
      is_addr_q <= is_addr_d;
      restart_q <= restart_d;
      scl_q <= scl_d;
      oe_q <= oe_d;
      cmd_ready_q <= cmd_ready_d;
      rd_valid_q <= rd_valid_d;
      rd_data_q <= rd_data_d;
      done_q <= done_d;
      nack_q <= nack_d;
      sda_s1_q <= link.sda;
      sda_s2_q <= sda_s1_q;
    end
  end
endmodule // tw_master

// >>> test/tw_link_assertions.sv
`timescale 1ns/100ps
module tw_link_assertions (
  input logic clock,
  input logic nrst,
  input logic scl,
  input logic sda_m_o,
  input logic sda_m_oe,
  input logic sda_s_o,
  input logic sda_s_oe,
  input logic sda
);
  logic scl_q, sda_q, seen_q, seen_d, start_w;
  logic [4:0] cnt_q, cnt_d;
  // seen marks the first device drive since the last start
  always_comb begin
    start_w = scl && scl_q && sda_q && !sda;
    cnt_d = cnt_q;
    seen_d = seen_q;
    if (start_w) begin
      cnt_d = 5'h00;
      seen_d = 1'h0;
    end else begin
      if (scl && !scl_q) cnt_d = cnt_q + 5'h01;
      if (sda_s_oe) seen_d = 1'h1;
    end
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
      cnt_q <= 5'h00;
      seen_q <= 1'h0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      cnt_q <= cnt_d;
      seen_q <= seen_d;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  property p_open_drain; !sda_m_o && !sda_s_o; endproperty
  property p_dev_edge; $changed(sda_s_oe) |-> !scl; endproperty
  property p_start_hold; start_w |-> scl [*4] ##[1:40] !scl; endproperty
  property p_ack_slot;
    $rose(sda_s_oe) && !seen_q |-> cnt_q == 5'h08 ##[1:40] ($rose(scl) && !sda);
  endproperty
  property p_ack_hold; $rose(sda_s_oe) |-> sda_s_oe [*8]; endproperty
  property p_scl_low; $fell(scl) |-> !scl [*8]; endproperty
  property p_scl_high; $rose(scl) |-> scl [*8]; endproperty
  property p_idle_reset;
    $rose(nrst) |-> scl && !sda_m_oe && !sda_s_oe;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("data line driven high");
  a_dev_edge: assert property (p_dev_edge)
    else $error("device changed data while clock high");
  a_start_hold: assert property (p_start_hold)
    else $error("start not followed by clock low");
  a_ack_slot: assert property (p_ack_slot)
    else $error("first device drive not in ninth bit");
  a_ack_hold: assert property (p_ack_hold)
    else $error("device drive too short");
  a_scl_low: assert property (p_scl_low)
    else $error("clock low phase too short");
  a_scl_high: assert property (p_scl_high)
    else $error("clock high phase too short");
  a_idle_reset: assert property (p_idle_reset)
    else $error("bus not idle after reset");
  c_start: cover property (start_w);
  c_ack: cover property ($rose(sda_s_oe) && !seen_q);
  c_nack: cover property (start_w ##[1:400] (cnt_q == 5'h09 && !seen_q));
endmodule // tw_link_assertions

// >>> test/two_wire_eeprom_write_path_tb.sv
`timescale 1ns/100ps
module two_wire_eeprom_write_path_tb;
  localparam int PROG = 2000;
  typedef struct packed {logic rd; logic [6:0] addr; logic [2:0] len;} tw_row_s;
  localparam tw_row_s ROWS [7] = '{'{1'h0, 7'h10, 3'h1}, '{1'h1, 7'h10, 3'h1},
    '{1'h0, 7'h25, 3'h4}, '{1'h1, 7'h24, 3'h4}, '{1'h0, 7'h00, 3'h4},
    '{1'h1, 7'h7e, 3'h3}, '{1'h0, 7'h0e, 3'h2}};
  logic clock, nrst, lock, cmd_valid, cmd_ready, cmd_read, cmd_poll;
  logic wr_valid, wr_ready, rd_valid, done, nack, busy;
  logic [6:0] cmd_addr;
  logic [2:0] cmd_len;
  logic [7:0] wr_data, rd_data, seq;
  logic [7:0] mem [128];
  logic [7:0] got [$];
  int failures, compares, n;
  tw_link_if tw_link_if_inst ();
  tw_eeprom #(.PROG_CYCLES(PROG)) tw_eeprom_inst (.clock(clock), .nrst(nrst),
    .link(tw_link_if_inst.device), .write_lock_input(lock), .busy(busy));
  tw_master #(.QTR_CYCLES(8)) tw_master_inst (.clock(clock), .nrst(nrst),
    .link(tw_link_if_inst.master), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_poll(cmd_poll),
    .cmd_addr(cmd_addr), .cmd_len(cmd_len), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
    .rd_data(rd_data), .done(done), .nack(nack));
  tw_link_assertions tw_link_assertions_inst (.clock(clock), .nrst(nrst),
    .scl(tw_link_if_inst.scl), .sda_m_o(tw_link_if_inst.sda_m_o),
    .sda_m_oe(tw_link_if_inst.sda_m_oe), .sda_s_o(tw_link_if_inst.sda_s_o),
    .sda_s_oe(tw_link_if_inst.sda_s_oe), .sda(tw_link_if_inst.sda));
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic test_done;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // page slot: only the two low address bits advance
  function automatic void put(input logic [6:0] a, input int i,
                              input logic [7:0] d);
    mem[{a[6:2], 2'(a[1:0] + 2'(i))}] = d;
  endfunction
  task automatic push(input logic [7:0] d);
    @(negedge clock);
    while (wr_ready !== 1'h1) @(negedge clock);
    wr_valid = 1'h1;
    wr_data = d;
    @(negedge clock);
    wr_valid = 1'h0;
  endtask
  task automatic run(input logic r, input logic p, input logic [6:0] a,
                     input logic [2:0] l);
    got = {};
    @(negedge clock);
    while (cmd_ready !== 1'h1) @(negedge clock);
    {cmd_valid, cmd_read, cmd_poll, cmd_addr, cmd_len} = {1'h1, r, p, a, l};
    @(negedge clock);
    cmd_valid = 1'h0;
    while (done !== 1'h1) begin
      if (rd_valid === 1'h1) got.push_back(rd_data);
      @(negedge clock);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [2:0] l, input logic u);
    for (int i = 0; i < l; i++) begin
      seq++;
      push(seq);
      if (u) put(a, i, seq);
    end
    run(1'h0, 1'h1, a, l);
  endtask
  task automatic rd(input logic [6:0] a, input logic [2:0] l);
    run(1'h1, 1'h1, a, l);
    check(8'(got.size()), 8'(l));
    for (int i = 0; i < got.size(); i++) check(got[i], mem[7'(a + 7'(i))]);
  endtask
  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end
  // about 1.7 times the expected run, still under the cycle budget
  initial begin
    #(900_000);
    failures++;
    test_done();
  end
  initial begin
    {nrst, lock, cmd_valid, cmd_read, cmd_poll, wr_valid} = 6'h00;
    {cmd_addr, cmd_len, wr_data, seq} = '0;
    failures = 0;
    compares = 0;
    for (int i = 0; i < 128; i++) mem[i] = 8'hff;
    repeat (5) @(negedge clock);
    nrst = 1'h1;
    @(negedge clock);
    check({cmd_ready, busy, nack, done}, 8'h08);
    check({tw_link_if_inst.scl, tw_link_if_inst.sda}, 8'h03);
    foreach (ROWS[k]) begin
      if (ROWS[k].rd) rd(ROWS[k].addr, ROWS[k].len);
      else wr(ROWS[k].addr, ROWS[k].len, 1'h1);
    end
    rd(7'h0c, 3'h4);
    // second request during the program cycle must get no answer
    wr(7'h50, 3'h1, 1'h1);
    n = 0;
    while (busy !== 1'h1 && n < 50) begin n++; @(negedge clock); end
    check(busy, 8'h01);
    n = 0;
    fork
      while (busy === 1'h1) begin n++; @(negedge clock); end
      run(1'h1, 1'h0, 7'h50, 3'h1);
    join
    check(nack, 8'h01);
    check(8'(got.size()), 8'h00);
    check(8'(n <= PROG && n > PROG - 100), 8'h01);
    rd(7'h50, 3'h1);
    lock = 1'h1;
    wr(7'h44, 3'h1, 1'h0);
    check(nack, 8'h01);
    repeat (50) @(negedge clock);
    check(busy, 8'h00);
    lock = 1'h0;
    rd(7'h44, 3'h1);
    // fill the write buffer until it refuses, then drain by page writes
    n = 0;
    @(negedge clock);
    while (wr_ready === 1'h1 && n < 40) begin
      wr_valid = 1'h1;
      wr_data = 8'(8'h80 + n);
      put(7'(7'h60 + 4 * (n / 4)), n % 4, wr_data);
      n++;
      @(negedge clock);
    end
    wr_valid = 1'h0;
    check(8'(n), 8'h20);
    for (int k = 0; k < 8; k++) run(1'h0, 1'h1, 7'(7'h60 + 4 * k), 3'h4);
    check(wr_ready, 8'h01);
    rd(7'h7a, 3'h6);
    test_done();
  end
endmodule // two_wire_eeprom_write_path_tb
